//--- dv/jvf_bus_model.sv
`timescale 1ns/100ps
`default_nettype none

module jvf_bus_model (
    // clock
    input  wire logic ref_clk,
    // transceiver lines
    input  wire logic tx_active,
    output logic      rx_filt
);
    logic       rem;   // level driven by the remote node
    logic [1:0] dly_r; // transceiver echo delay

    initial begin
        rem   = 1'b0;
        dly_r = 2'b00;
    end

    // wired-or bus: the active level wins, echo two cycles late
    always @(posedge ref_clk) begin
        dly_r <= {dly_r[0], rem | tx_active};
    end
    assign rx_filt = dly_r[1];

    // hold one level for n cycles
    task automatic sym(input logic lvl, input int n);
        rem <= lvl;
        repeat (n) @(posedge ref_clk);
    endtask

    // remote frame of two bytes, msb first
    task automatic send(input logic [15:0] w);
        sym(1'b1, 2000);
        for (int k = 0; k < 16; k++) begin
            // even places passive, odd active
            if (k % 2 == 0) sym(1'b0, w[15 - k] ? 1280 : 640);
            else sym(1'b1, w[15 - k] ? 640 : 1280);
        end
        rem <= 1'b0;
    endtask
endmodule // jvf_bus_model

`default_nettype wire

//--- dv/jvf_framer_properties.sv
`timescale 1ns/100ps
`default_nettype none

module jvf_framer_properties
    import jvf_pkg::*;
#(
    // active run that counts as a break
    parameter logic [11:0] RX_BRK_CYC = 12'(T_BREAK_US * CLK_PER_US)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // transceiver lines
    input wire logic rx_filt,
    input wire logic tx_active
);
    import jvf_pkg::*;

    logic [11:0] hi_r, hi_nxt;   // tx active run, saturating
    logic [11:0] lo_r, lo_nxt;   // tx passive run, saturating
    logic [11:0] rxh_r, rxh_nxt; // rx active run, saturating
    logic [5:0]  fc_r, fc_nxt;   // tx falls since start of frame
    logic        sof_r, sof_nxt; // last rise opened a frame
    logic        ab_r, ab_nxt;   // break seen since that rise
    logic        rise, fall;     // tx edges at this sample

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // edges come from the run counters, which saves a delay flop
    always_comb begin
        rise    = tx_active && hi_r == 12'h000;
        fall    = !tx_active && hi_r != 12'h000;
        hi_nxt  = tx_active ? hi_r + 12'(hi_r != 12'hFFF) : 12'h000;
        lo_nxt  = tx_active ? 12'h000 : lo_r + 12'(lo_r != 12'hFFF);
        rxh_nxt = rx_filt ? rxh_r + 12'(rxh_r != 12'hFFF) : 12'h000;
        sof_nxt = rise ? (lo_r > 12'h500) : sof_r;
        fc_nxt  = (rise && lo_r > 12'h500) ? 6'h00 : fc_r + 6'(fall);
        ab_nxt  = (rise && lo_r > 12'h500) ? 1'b0 : (ab_r || rxh_r >= RX_BRK_CYC);
    end

    // reset counts as a long idle so the first rise is a frame start
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hi_r  <= 12'h000;
            lo_r  <= 12'hFFF;
            rxh_r <= 12'h000;
            fc_r  <= 6'h00;
            sof_r <= 1'b0;
            ab_r  <= 1'b0;
        end else begin
            hi_r  <= hi_nxt;
            lo_r  <= lo_nxt;
            rxh_r <= rxh_nxt;
            fc_r  <= fc_nxt;
            sof_r <= sof_nxt;
            ab_r  <= ab_nxt;
        end
    end

    property p_sof_len;
        fall && sof_r && !ab_r |-> hi_r == 12'h7D0;
    endproperty
    a_sof_len: assert property (p_sof_len) else $error("frame start not 2000 cycles");
    property p_no_break;
        tx_active |-> hi_r < 12'h7D0;
    endproperty
    a_no_break: assert property (p_no_break) else $error("tx active too long");
    property p_bit_hi;
        fall && !sof_r && !ab_r |-> hi_r == 12'h280 || hi_r == 12'h500;
    endproperty
    a_bit_hi: assert property (p_bit_hi) else $error("active bit length");
    property p_bit_lo;
        rise && lo_r <= 12'h500 |-> lo_r == 12'h280 || lo_r == 12'h500;
    endproperty
    a_bit_lo: assert property (p_bit_lo) else $error("passive bit length");
    property p_sof_gap;
        rise && lo_r > 12'h500 |-> lo_r >= 12'hAF0;
    endproperty
    a_sof_gap: assert property (p_sof_gap) else $error("frame start too early");
    property p_break_stop;
        rxh_r > RX_BRK_CYC + 12'h00A |-> !tx_active;
    endproperty
    a_break_stop: assert property (p_break_stop) else $error("tx during break");
    property p_break_hold;
        $rose(ab_r) |-> ##8 !tx_active [*8];
    endproperty
    a_break_hold: assert property (p_break_hold) else $error("tx not halted");
    property p_byte_cnt;
        lo_r == 12'h6A4 && fc_r != 6'h00 && !ab_r |-> fc_r >= 6'h09 && fc_r[1:0] == 2'b01;
    endproperty
    a_byte_cnt: assert property (p_byte_cnt) else $error("frame not whole bytes");
endmodule // jvf_framer_properties

bind jvf_framer jvf_framer_properties #(.RX_BRK_CYC(RX_BRK_CYC)) u_props (
    .ref_clk(ref_clk), .rstn(rstn), .rx_filt(rx_filt), .tx_active(tx_active)
);

`default_nettype wire

//--- dv/jvf_framer_tb.sv
`timescale 1ns/100ps
`default_nettype none

module jvf_framer_tb;
    import jvf_pkg::*;

    logic        ref_clk, rstn, bus_wr, bus_rd, rx_filt, tx_active;
    logic [7:0]  bus_addr;
    logic [31:0] bus_wdata, bus_rdata;
    logic [31:0] rd_v;    // last read value
    logic [7:0]  chk;     // check byte for data 0x55
    logic        last_tx; // tx level at the previous edge
    int          run;     // cycles in the current tx level
    int          runs[$]; // finished tx runs
    int          n_errors, samples_checked;

    jvf_framer dut (
        .ref_clk(ref_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .rx_filt(rx_filt), .tx_active(tx_active)
    );
    jvf_bus_model bus (.ref_clk(ref_clk), .tx_active(tx_active), .rx_filt(rx_filt));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // tx run lengths as sampled at each edge
    always @(posedge ref_clk) begin
        if (tx_active !== last_tx) begin
            runs.push_back(run);
            run = 0;
        end
        run++;
        last_tx = tx_active;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    // low four status flags
    task automatic st(input logic [3:0] e);
        rd(ADDR_STATUS, rd_v);
        check("flags", 32'(rd_v[3:0]), 32'(e));
    endtask

    function automatic logic [7:0] crc_of(input logic [7:0] b);
        logic [7:0] c;
        c = CRC_PRESET;
        for (int i = 7; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
        end
        return ~c;
    endfunction

    // expected length of bit k: even places passive
    function automatic logic [31:0] exp_run(input int k, input logic [15:0] w);
        if (k % 2 == 0) return w[15 - k] ? 32'h500 : 32'h280;
        return w[15 - k] ? 32'h280 : 32'h500;
    endfunction

    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // the run needs about 90k cycles
    initial begin
        cyc(100000);
        n_errors++;
        print_verdict();
    end

    initial begin
        rstn = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        last_tx = 1'b0;
        run = 0;
        n_errors = 0;
        samples_checked = 0;
        chk = crc_of(8'h55);
        cyc(8);
        rstn <= 1'b1;
        cyc(3100);
        // idle after reset: ready and idle only
        rd(ADDR_STATUS, rd_v);
        check("status", 32'(rd_v[7:0]), 32'h60);
        // one byte sent: 0x55 gives only short bits
        runs.delete();
        wr(ADDR_TXDATA, 32'h155);
        for (int i = 0; i < 20000 && runs.size() < 18; i++) @(posedge ref_clk);
        check("sof run", 32'(runs[1]), 32'h7D0);
        for (int k = 0; k < 16; k++) check("tx run", 32'(runs[k + 2]), exp_run(k, {8'h55, chk}));
        cyc(2900);
        st(4'b0010);
        // remote frames, good then corrupted check byte
        bus.send({8'h55, chk});
        cyc(2900);
        st(4'b0010);
        // last complete byte of the remote frame is its check byte
        rd(ADDR_RXDATA, rd_v);
        check("rx byte", rd_v, 32'(chk));
        bus.send({8'h55, chk ^ 8'h01});
        cyc(2900);
        st(4'b0011);
        // break inside a quad speed frame
        wr(ADDR_CTRL, 32'h1);
        bus.sym(1'b1, 500);
        bus.sym(1'b0, 160);
        bus.sym(1'b1, 3000);
        bus.sym(1'b0, 3100);
        rd(ADDR_STATUS, rd_v);
        check("invalid", 32'(rd_v[ST_INV_BIT]), 32'h1);
        rd(ADDR_CTRL, rd_v);
        check("fast", 32'(rd_v[CTRL_FAST_BIT]), 32'h0);
        // break while sending
        wr(ADDR_TXDATA, 32'h155);
        cyc(2099);
        // mid frame: busy, holding stage empty, bus not idle
        rd(ADDR_STATUS, rd_v);
        check("busy", 32'(rd_v[7:5]), 32'h5);
        bus.sym(1'b1, 3000);
        check("tx halted", 32'(tx_active), 32'h0);
        bus.sym(1'b0, 3100);
        rd(ADDR_STATUS, rd_v);
        check("tx error", 32'(rd_v[ST_TXERR_BIT]), 32'h1);
        // pending send joins a remote start inside the separation
        fork
            bus.send({8'h55, chk});
            begin
                cyc(3000);
                wr(ADDR_TXDATA, 32'h155);
            end
        join
        cyc(2850);
        bus.sym(1'b1, 20);
        check("resync", 32'(tx_active), 32'h1);
        bus.sym(1'b0, 100);
        print_verdict();
    end
endmodule // jvf_framer_tb

`default_nettype wire

//--- hdl/jvf_framer.sv
`timescale 1ns/100ps
`default_nettype none

module jvf_framer
    import jvf_pkg::*;
#(
    // receive thresholds in cycles
    parameter logic [11:0] RX_MIN_CYC   = 12'(RX_MIN_US * CLK_PER_US),
    parameter logic [11:0] RX_SHORT_CYC = 12'(RX_SHORT_US * CLK_PER_US),
    parameter logic [11:0] RX_LONG_CYC  = 12'(RX_LONG_US * CLK_PER_US),
    parameter logic [11:0] RX_BRK_CYC   = 12'(T_BREAK_US * CLK_PER_US),
    parameter logic [11:0] RX_EOF_CYC   = 12'(T_EOF_US * CLK_PER_US),
    parameter logic [11:0] RX_IFS_CYC   = 12'((T_EOF_US + T_IFS_US) * CLK_PER_US)
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    // transceiver side
    input  wire logic        rx_filt,
    output logic             tx_active
);
    import jvf_pkg::*;

    // scale a threshold for quad speed reception
    function automatic logic [11:0] thr(input logic [11:0] t, input logic q);
        thr = q ? {2'b00, t[11:2]} : t;
    endfunction

    // one serial crc step
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
    endfunction

    // receive pin synchroniser
    logic rx_s1_r, rx_s2_r, rx_s3_r;   // three stage chain
    logic rx_lvl_r, rx_lvl_nxt;        // accepted level, high = active

    // level changes only once the last two stages agree
    always_comb begin
        rx_lvl_nxt = rx_lvl_r;
        if (rx_s2_r == rx_s3_r) begin
            rx_lvl_nxt = rx_s3_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_s1_r  <= 1'b0;
            rx_s2_r  <= 1'b0;
            rx_s3_r  <= 1'b0;
            rx_lvl_r <= 1'b0;
        end else begin
            rx_s1_r  <= rx_filt;
            rx_s2_r  <= rx_s1_r;
            rx_s3_r  <= rx_s2_r;
            rx_lvl_r <= rx_lvl_nxt;
        end
    end

    // main state
    logic [7:0]    ctrl_r, ctrl_nxt;          // control register
    jvf_flags_t    flg_r, flg_nxt;            // sticky flags
    logic [31:0]   rdata_r, rdata_nxt;        // read data, one cycle late
    // receiver
    logic [11:0]   rx_cnt_r, rx_cnt_nxt;      // cycles since last edge
    logic          in_frame_r, in_frame_nxt;  // between SOF and EOF
    logic          rx_data_r, rx_data_nxt;    // data phase, cleared at EOD
    logic          nb_r, nb_nxt;              // next active bit is the NB
    logic [2:0]    rx_bits_r, rx_bits_nxt;    // bits in current byte
    logic [7:0]    rx_sh_r, rx_sh_nxt;        // receive shifter
    logic [7:0]    rx_crc_r, rx_crc_nxt;      // receive remainder
    logic [7:0]    rx_byte_r, rx_byte_nxt;    // last complete byte
    logic          rx_full_r, rx_full_nxt;    // byte waiting for host
    logic          idle_r, idle_nxt;          // bus idle seen
    // transmitter
    jvf_tx_state_t tx_st_r, tx_st_nxt;
    logic [11:0]   tx_cnt_r, tx_cnt_nxt;      // remaining cycles of symbol
    logic          tx_lvl_r, tx_lvl_nxt;      // driven level, high = active
    logic [7:0]    tx_sh_r, tx_sh_nxt;        // transmit shifter
    logic [2:0]    tx_bits_r, tx_bits_nxt;    // bits left minus one
    logic          tx_last_r, tx_last_nxt;    // current byte is last data
    logic          tx_ck_r, tx_ck_nxt;        // sending the check byte
    logic [7:0]    tx_crc_r, tx_crc_nxt;      // transmit remainder
    logic [8:0]    hold_r, hold_nxt;          // one byte holding stage
    logic          hold_v_r, hold_v_nxt;

    logic          rx_edge, rx_rise, rx_fall, q;
    logic [11:0]   len;
    logic [7:0]    ck_byte;
    logic          bit_v;

    always_comb begin
        ctrl_nxt     = ctrl_r;
        flg_nxt      = flg_r;
        rdata_nxt    = 32'h0000_0000;
        rx_cnt_nxt   = rx_cnt_r;
        in_frame_nxt = in_frame_r;
        rx_data_nxt  = rx_data_r;
        nb_nxt       = nb_r;
        rx_bits_nxt  = rx_bits_r;
        rx_sh_nxt    = rx_sh_r;
        rx_crc_nxt   = rx_crc_r;
        rx_byte_nxt  = rx_byte_r;
        rx_full_nxt  = rx_full_r;
        idle_nxt     = idle_r;
        tx_st_nxt    = tx_st_r;
        tx_cnt_nxt   = tx_cnt_r;
        tx_lvl_nxt   = tx_lvl_r;
        tx_sh_nxt    = tx_sh_r;
        tx_bits_nxt  = tx_bits_r;
        tx_last_nxt  = tx_last_r;
        tx_ck_nxt    = tx_ck_r;
        tx_crc_nxt   = tx_crc_r;
        hold_nxt     = hold_r;
        hold_v_nxt   = hold_v_r;
        ck_byte      = 8'h00;
        bit_v        = 1'b0;

        q       = ctrl_r[CTRL_FAST_BIT];
        rx_edge = rx_lvl_nxt != rx_lvl_r;
        rx_rise = rx_edge && rx_lvl_nxt;
        rx_fall = rx_edge && !rx_lvl_nxt;
        len     = rx_cnt_r;

        // host access; clears come first so hardware sets win
        if (bus_rd) begin
            if (bus_addr == ADDR_CTRL) begin
                rdata_nxt = {24'h000000, ctrl_r};
            end else if (bus_addr == ADDR_STATUS) begin
                rdata_nxt = {24'h000000, tx_st_r != JVF_TX_IDLE, idle_r, !hold_v_r,
                             rx_full_r, flg_r};
                flg_nxt   = '0;
            end else if (bus_addr == ADDR_RXDATA) begin
                rdata_nxt   = {24'h000000, rx_byte_r};
                rx_full_nxt = 1'b0;
            end else begin
                rdata_nxt = 32'h0000_0000;                        // unmapped reads zero
            end
        end
        if (bus_wr) begin
            if (bus_addr == ADDR_CTRL) begin
                ctrl_nxt = {7'h00, bus_wdata[CTRL_FAST_BIT]};
            end else if (bus_addr == ADDR_TXDATA && !hold_v_r) begin
                // a write while the holding stage is full is dropped
                hold_nxt   = bus_wdata[TXD_LAST_BIT:0];
                hold_v_nxt = 1'b1;
            end
        end

        // receive timing
        if (rx_edge) begin
            rx_cnt_nxt = 12'h000;
        end else if (rx_cnt_r != 12'hFFF) begin
            rx_cnt_nxt = rx_cnt_r + 12'h001;
        end

        if (rx_lvl_r && !rx_edge && rx_cnt_r == thr(RX_BRK_CYC, q)) begin
            // active too long: BREAK
            if (in_frame_r) begin
                flg_nxt.inv_sym = 1'b1;
                in_frame_nxt    = 1'b0;
                if (q) begin
                    ctrl_nxt[CTRL_FAST_BIT] = 1'b0;
                end
            end
            if (tx_st_r != JVF_TX_IDLE && tx_st_r != JVF_TX_WAIT) begin
                flg_nxt.tx_err = 1'b1;
                tx_st_nxt      = JVF_TX_IDLE;
                tx_lvl_nxt     = 1'b0;
            end
        end
        if (!rx_lvl_r && !rx_edge) begin
            if (rx_cnt_r == thr(RX_LONG_CYC, q) && in_frame_r && rx_data_r) begin
                // end of data: check the remainder, raise nothing else
                rx_data_nxt = 1'b0;
                if (rx_crc_r != CRC_GOOD || rx_bits_r != 3'd0) begin
                    flg_nxt.crc_err = 1'b1;
                end
            end
            if (rx_cnt_r == thr(RX_EOF_CYC, q) && in_frame_r) begin
                flg_nxt.eof  = 1'b1;
                in_frame_nxt = 1'b0;
            end
            if (rx_cnt_r >= thr(RX_IFS_CYC, q)) begin
                idle_nxt = 1'b1;
            end
        end
        if (rx_edge) begin
            idle_nxt = 1'b0;
        end

        // symbol classification at each edge
        if (rx_fall) begin
            // an active period just ended
            if (len >= thr(RX_LONG_CYC, q) && len < thr(RX_BRK_CYC, q)) begin
                in_frame_nxt = 1'b1;                              // SOF
                rx_data_nxt  = 1'b1;
                nb_nxt       = 1'b0;
                rx_bits_nxt  = 3'd0;
                rx_crc_nxt   = CRC_PRESET;
            end else if (in_frame_r && len < thr(RX_MIN_CYC, q)) begin
                flg_nxt.inv_sym = 1'b1;
                in_frame_nxt    = 1'b0;
            end else if (in_frame_r && len < thr(RX_LONG_CYC, q)) begin
                if (nb_r) begin
                    nb_nxt = 1'b0;
                end else begin
                    bit_v = 1'b1;
                end
            end
        end
        if (rx_rise && in_frame_r) begin
            // a passive period just ended
            if (len < thr(RX_MIN_CYC, q)) begin
                flg_nxt.inv_sym = 1'b1;
                in_frame_nxt    = 1'b0;
            end else if (len >= thr(RX_LONG_CYC, q)) begin
                // response after end of data: NB first, then fresh crc
                rx_data_nxt = 1'b1;
                nb_nxt      = 1'b1;
                rx_bits_nxt = 3'd0;
                rx_crc_nxt  = CRC_PRESET;
            end else begin
                bit_v = 1'b1;
            end
        end
        if (bit_v) begin
            // active short or passive long is a one
            rx_sh_nxt   = {rx_sh_r[6:0], rx_lvl_r ^ (len >= thr(RX_SHORT_CYC, q))};
            rx_crc_nxt  = crc_step(rx_crc_r, rx_sh_nxt[0]);
            rx_bits_nxt = rx_bits_r + 3'd1;
            if (rx_bits_r == 3'd7) begin
                rx_byte_nxt = rx_sh_nxt;
                rx_full_nxt = 1'b1;
            end
        end

        // transmitter
        if (tx_cnt_r != 12'h000) begin
            tx_cnt_nxt = tx_cnt_r - 12'h001;
        end
        case (tx_st_r)
            JVF_TX_IDLE: begin
                tx_lvl_nxt = 1'b0;
                if (hold_v_r) begin
                    tx_sh_nxt   = hold_r[7:0];
                    tx_last_nxt = hold_r[8];
                    hold_v_nxt  = 1'b0;
                    tx_st_nxt   = JVF_TX_WAIT;
                end
            end
            JVF_TX_WAIT: begin
                // full EOF plus IFS, or a peer's SOF edge after EOF
                if ((!rx_lvl_r && rx_cnt_r >= RX_IFS_CYC)
                    || (rx_rise && rx_cnt_r >= RX_EOF_CYC)) begin
                    tx_st_nxt  = JVF_TX_SOF;
                    tx_lvl_nxt = 1'b1;
                    tx_cnt_nxt = TX_SOF_CYC - 12'h001;
                    tx_crc_nxt = CRC_PRESET;
                    tx_ck_nxt  = 1'b0;
                end
            end
            JVF_TX_SOF: begin
                if (tx_cnt_r == 12'h000) begin
                    tx_st_nxt   = JVF_TX_BIT;
                    tx_lvl_nxt  = 1'b0;                           // first bit passive
                    tx_bits_nxt = 3'd7;
                    tx_cnt_nxt  = (tx_sh_r[7] ? TX_LONG_CYC : TX_SHORT_CYC) - 12'h001;
                end
            end
            JVF_TX_BIT: begin
                if (tx_cnt_r == 12'h000) begin
                    if (!tx_ck_r) begin
                        tx_crc_nxt = crc_step(tx_crc_r, tx_sh_r[7]);
                    end
                    tx_sh_nxt   = {tx_sh_r[6:0], 1'b0};               // MSB first
                    tx_bits_nxt = tx_bits_r - 3'd1;
                    tx_lvl_nxt  = !tx_lvl_r;
                    if (tx_bits_r == 3'd0) begin
                        tx_bits_nxt = 3'd7;
                        tx_lvl_nxt  = 1'b0;
                        ck_byte     = ~tx_crc_nxt;
                        if (tx_ck_r) begin
                            tx_st_nxt = JVF_TX_IDLE;                  // passive tail is EOD
                        end else if (tx_last_r) begin
                            tx_sh_nxt = ck_byte;
                            tx_ck_nxt = 1'b1;
                        end else if (hold_v_r) begin
                            tx_sh_nxt   = hold_r[7:0];
                            tx_last_nxt = hold_r[8];
                            hold_v_nxt  = 1'b0;
                        end else begin
                            // host failed to supply the next byte in time
                            flg_nxt.tx_err = 1'b1;
                            tx_st_nxt      = JVF_TX_IDLE;
                        end
                    end
                    // passive: 1 long; active: 0 long
                    tx_cnt_nxt = ((tx_sh_nxt[7] ^ tx_lvl_nxt) ? TX_LONG_CYC
                                                              : TX_SHORT_CYC) - 12'h001;
                end
            end
            default: begin
                tx_st_nxt = JVF_TX_IDLE;
            end
        endcase
    end

    // register the main state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r     <= CTRL_RESET;
            flg_r      <= '0;
            rdata_r    <= 32'h0000_0000;
            rx_cnt_r   <= 12'h000;
            in_frame_r <= 1'b0;
            rx_data_r  <= 1'b0;
            nb_r       <= 1'b0;
            rx_bits_r  <= 3'd0;
            rx_sh_r    <= 8'h00;
            rx_crc_r   <= CRC_PRESET;
            rx_byte_r  <= 8'h00;
            rx_full_r  <= 1'b0;
            idle_r     <= 1'b0;
            tx_st_r    <= JVF_TX_IDLE;
            tx_cnt_r   <= 12'h000;
            tx_lvl_r   <= 1'b0;
            tx_sh_r    <= 8'h00;
            tx_bits_r  <= 3'd0;
            tx_last_r  <= 1'b0;
            tx_ck_r    <= 1'b0;
            tx_crc_r   <= CRC_PRESET;
            hold_r     <= 9'h000;
            hold_v_r   <= 1'b0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            flg_r      <= flg_nxt;
            rdata_r    <= rdata_nxt;
            rx_cnt_r   <= rx_cnt_nxt;
            in_frame_r <= in_frame_nxt;
            rx_data_r  <= rx_data_nxt;
            nb_r       <= nb_nxt;
            rx_bits_r  <= rx_bits_nxt;
            rx_sh_r    <= rx_sh_nxt;
            rx_crc_r   <= rx_crc_nxt;
            rx_byte_r  <= rx_byte_nxt;
            rx_full_r  <= rx_full_nxt;
            idle_r     <= idle_nxt;
            tx_st_r    <= tx_st_nxt;
            tx_cnt_r   <= tx_cnt_nxt;
            tx_lvl_r   <= tx_lvl_nxt;
            tx_sh_r    <= tx_sh_nxt;
            tx_bits_r  <= tx_bits_nxt;
            tx_last_r  <= tx_last_nxt;
            tx_ck_r    <= tx_ck_nxt;
            tx_crc_r   <= tx_crc_nxt;
            hold_r     <= hold_nxt;
            hold_v_r   <= hold_v_nxt;
        end
    end

    // outputs straight from flops
    assign bus_rdata = rdata_r;
    assign tx_active = tx_lvl_r;

endmodule // jvf_framer

`default_nettype wire

//--- hdl/jvf_pkg.sv
`default_nettype none

package jvf_pkg;

    // clock rate in cycles per microsecond (10 MHz)
    localparam int CLK_PER_US = 10;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0C;

    // control register fields
    localparam int CTRL_FAST_BIT = 0;   // fast_receive_enable
    // tx data register fields
    localparam int TXD_LAST_BIT  = 8;   // byte is the last data byte
    // status register fields
    localparam int ST_CRC_BIT    = 0;
    localparam int ST_EOF_BIT    = 1;
    localparam int ST_INV_BIT    = 2;
    localparam int ST_TXERR_BIT  = 3;
    localparam int ST_RXFULL_BIT = 4;
    localparam int ST_TXRDY_BIT  = 5;
    localparam int ST_IDLE_BIT   = 6;
    localparam int ST_TXBUSY_BIT = 7;

    // crc constants
    localparam logic [7:0] CRC_POLY  = 8'h1D;   // x^8 + x^4 + x^3 + x^2 + 1
    localparam logic [7:0] CRC_PRESET = 8'hFF;
    localparam logic [7:0] CRC_GOOD  = 8'hC4;

    // nominal symbol times in microseconds
    localparam int T_SHORT_US = 64;
    localparam int T_LONG_US  = 128;
    localparam int T_SOF_US   = 200;
    localparam int T_EOD_US   = 200;
    localparam int T_EOF_US   = 280;
    localparam int T_IFS_US   = 20;
    localparam int T_BREAK_US = 240;

    // transmit durations in cycles
    localparam logic [11:0] TX_SHORT_CYC = 12'(T_SHORT_US * CLK_PER_US);
    localparam logic [11:0] TX_LONG_CYC  = 12'(T_LONG_US * CLK_PER_US);
    localparam logic [11:0] TX_SOF_CYC   = 12'(T_SOF_US * CLK_PER_US);

    // default receive thresholds in microseconds (bounds of abutting windows)
    localparam int RX_MIN_US   = 34;    // shortest valid bit
    localparam int RX_SHORT_US = 96;    // short / long boundary
    localparam int RX_LONG_US  = 163;   // long bit / sof or eod boundary

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;

    typedef enum {
        JVF_TX_IDLE,
        JVF_TX_WAIT,
        JVF_TX_SOF,
        JVF_TX_BIT
    } jvf_tx_state_t;

    // sticky status flags, cleared by a status read
    typedef struct packed {
        logic tx_err;
        logic inv_sym;
        logic eof;
        logic crc_err;
    } jvf_flags_t;

endpackage

`default_nettype wire
